// *** verilog/pbm_pkg.sv ***
// Package: constants and carriers for the PCI-to-processor-bus master
package pbm_pkg;
   // =====================================================
   // Geometry
   localparam int DATA_W = 64;
   localparam int DFIFO_DEPTH = 8;
   localparam int DFIFO_AW = 3;
   localparam int CMD_W = 46;
   localparam int CFIFO_DEPTH = 4;
   localparam int CFIFO_AW = 2;
   localparam int LINE_DW = 4;
   localparam int ADDR_W = 32;
   localparam logic [3:0] CNT_ONE_LINE = 4'h4;
   localparam logic [3:0] CNT_FULL = 4'h8;
   localparam logic [5:0] PF_LINES_DW = 6'h10;
   // =====================================================
   // Processor transfer types
   localparam logic [4:0] TT_READ = 5'h0A;
   localparam logic [4:0] TT_RWITM = 5'h0E;
   localparam logic [4:0] TT_WKILL = 5'h06;
   localparam logic [4:0] TT_WFLUSH = 5'h02;
   // =====================================================
   // Register map
   localparam logic [3:0] REG_ATTR = 4'h0;
   localparam logic [3:0] REG_GCTL = 4'h4;
   localparam logic [3:0] REG_STAT = 4'h8;
   localparam logic [3:0] REG_LIMIT = 4'hC;
   localparam int ATTR_WFT_LO = 0;
   localparam int ATTR_WRITE_POST_ENABLE = 2;
   localparam int ATTR_READ_AHEAD_ENABLE = 3;
   localparam int ATTR_READ_ANY_THRESHOLD_LO = 4;
   localparam int ATTR_READ_MULTIPLE_THRESHOLD_LO = 6;
   localparam int ATTR_INV = 8;
   localparam int ATTR_GBL = 9;
   localparam int GCTL_HOG = 0;
   localparam logic [31:0] LIMIT_RST = 32'hFFFFFFFF;

   typedef struct packed {
      logic write;
      logic multiple;
      logic [ADDR_W-1:0] addr;
      logic [11:0] dwords;
   } pbm_cmd_t;

   typedef struct packed {
      logic req;
      logic [ADDR_W-1:0] addr;
      logic [4:0] ttype;
      logic burst;
      logic global;
   } pbm_bus_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ADDR = 4'b0010,
      ST_DATA = 4'b0100,
      ST_DONE = 4'b1000
   } pbm_state_t;
endpackage

// *** verilog/pbm_master.sv ***
// Processor-bus master with data and command FIFOs
`timescale 1ns/1ps
// What this block does
// - eight-entry 64-bit shared data FIFO
// - four-entry 46-bit command FIFO
// - withhold command acknowledge while command FIFO full, write ready while data FIFO full
// - every single beat stays its own beat
// - single beats or four-beat bursts only
// - unaligned write start: singles to line
// - unaligned write tail: finish with singles
// - read offsets 1-2 burst-discard with read ahead, single without; 3 single
// - write start and continue thresholds
// - filling and draining run concurrently
// - no read ahead: line on demand
// - read ahead one line at a time, refill on empty FIFO
// - discard leftover prefetch data on completion
// - never prefetch past decoder limit
// - read type by invalidate bit
// - write type kill burst, flush single
// - global bit drives snoop for all
// - bus hog requests for whole transfer
// - bus hog resets disabled
module pbm_master (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic cmd_valid,
   input wire pbm_pkg::pbm_cmd_t cmd_in,
   output logic cmd_ack,
   input wire logic wdata_valid,
   input wire logic [63:0] wdata_in,
   output logic wdata_ready,
   output logic rdata_valid,
   output logic [63:0] rdata_out,
   input wire logic rdata_ready,
   input wire logic pci_frame_active,
   input wire logic xfer_end,
   output pbm_pkg::pbm_bus_t bus_out,
   input wire logic bus_grant,
   input wire logic bus_aack,
   input wire logic bus_ta,
   input wire logic [63:0] bus_rdata,
   output logic [63:0] bus_wdata
);
   // =====================================================
   // Registers
   logic [9:0] attr;
   logic hog_en;
   logic [31:0] limit;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         attr <= 10'h000;
         hog_en <= 1'b0;
         limit <= pbm_pkg::LIMIT_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            pbm_pkg::REG_ATTR: attr <= reg_wdata[9:0];
            pbm_pkg::REG_GCTL: hog_en <= reg_wdata[pbm_pkg::GCTL_HOG];
            pbm_pkg::REG_LIMIT: limit <= reg_wdata;
            default: ;
         endcase
      end
   end
   wire logic [1:0] wft = attr[pbm_pkg::ATTR_WFT_LO +: 2];
   wire logic write_post_enable = attr[pbm_pkg::ATTR_WRITE_POST_ENABLE];
   wire logic read_ahead_enable = attr[pbm_pkg::ATTR_READ_AHEAD_ENABLE];
   wire logic [1:0] read_any_threshold = attr[pbm_pkg::ATTR_READ_ANY_THRESHOLD_LO +: 2];
   wire logic [1:0] read_multiple_threshold = attr[pbm_pkg::ATTR_READ_MULTIPLE_THRESHOLD_LO +: 2];
   wire logic invalidate_attr = attr[pbm_pkg::ATTR_INV];
   wire logic global_attr = attr[pbm_pkg::ATTR_GBL];

   // =====================================================
   // Command FIFO
   // four 46-bit command slots
   logic [pbm_pkg::CMD_W-1:0] cmem [pbm_pkg::CFIFO_DEPTH];
   logic [1:0] cwp, crp;
   logic [2:0] ccnt;
   wire logic cfull = (ccnt == 3'h4);
   // no acknowledge while command FIFO full
   wire logic cpush = cmd_valid && !cfull && !cmd_ack;
   logic cpop;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cwp <= 2'h0;
         crp <= 2'h0;
         ccnt <= 3'h0;
         cmd_ack <= 1'b0;
      end else begin
         cmd_ack <= cpush;
         if (cpush) begin
            cmem[cwp] <= cmd_in;
            cwp <= cwp + 2'h1;
         end
         if (cpop)
            crp <= crp + 2'h1;
         ccnt <= ccnt + {2'h0, cpush} - {2'h0, cpop};
      end
   end
   pbm_pkg::pbm_cmd_t chead;
   assign chead = cmem[crp];

   // =====================================================
   // Data FIFO, shared by both directions
   // eight 64-bit entries
   logic [63:0] dmem [pbm_pkg::DFIFO_DEPTH];
   logic [2:0] dwp, drp;
   logic [3:0] dcnt;
   logic dpush, dpop, dflush;
   logic [63:0] dpush_data;
   pbm_pkg::pbm_state_t state;
   logic cur_write;
   logic discard;
   // PCI side fills while bus side drains
   wire logic dfull = (dcnt == pbm_pkg::CNT_FULL);
   // Beat taken only with ready, so a held beat is never stored twice
   wire logic wr_push = wdata_valid && wdata_ready && !dfull && cur_write;
   wire logic rd_pop = rdata_valid && rdata_ready;
   always_comb begin
      dpush = 1'b0;
      dpush_data = wdata_in;
      if (cur_write) begin
         dpush = wr_push;
      end else if (state == pbm_pkg::ST_DATA && bus_ta && !discard) begin
         dpush = 1'b1;
         dpush_data = bus_rdata;
      end
   end
   always_ff @(posedge core_clk) begin
      if (srst || dflush) begin
         dwp <= 3'h0;
         drp <= 3'h0;
         dcnt <= 4'h0;
      end else begin
         if (dpush) begin
            dmem[dwp] <= dpush_data;
            dwp <= dwp + 3'h1;
         end
         if (dpop)
            drp <= drp + 3'h1;
         dcnt <= dcnt + {3'h0, dpush} - {3'h0, dpop};
      end
   end
   always_ff @(posedge core_clk) begin
      if (srst)
         wdata_ready <= 1'b0;
      else
         wdata_ready <= cur_write && (dcnt + {3'h0, dpush} < pbm_pkg::CNT_FULL);
   end

   // =====================================================
   // Transaction engine
   logic [31:0] addr;
   logic [12:0] left;
   logic [1:0] beat;
   logic [1:0] skip;
   logic burst;
   logic active;
   logic [5:0] pf_out;
   logic started;
   logic [3:0] wstart;
   // write start level by threshold code
   always_comb begin
      case (wft)
         2'b00: wstart = 4'h8;
         2'b01: wstart = 4'h8;
         2'b10: wstart = 4'h8;
         default: wstart = pbm_pkg::CNT_ONE_LINE;
      endcase
   end
   // FIFO holds two lines; codes asking for more start once it is full.
   wire logic [1:0] rth = chead.multiple ? read_multiple_threshold : read_any_threshold;
   wire logic [3:0] rlevel = {rth, 2'b00};
   wire logic at_line = (addr[4:3] == 2'b00);
   wire logic [12:0] to_line = 13'h4 - {11'h0, addr[4:3]};
   wire logic in_range = (addr <= limit);
   logic go;
   always_comb begin
      go = 1'b0;
      if (active && state == pbm_pkg::ST_IDLE && left != 13'h0) begin
         if (cur_write) begin
            if (!write_post_enable)
               go = (dcnt != 4'h0);
            else if (!started)
               go = (dcnt >= wstart) || (dcnt >= left[3:0] && left < 13'h8);
            else
               go = (dcnt >= pbm_pkg::CNT_ONE_LINE) || (dcnt >= left[3:0] && left < 13'h4);
         end else if (read_ahead_enable) begin
            // refill only once the FIFO is empty
            go = in_range && (pf_out == 6'h0 || dcnt <= rlevel) && (dcnt == 4'h0);
         end else begin
            // next line only while frame held and FIFO drained
            go = in_range && (!started || (pci_frame_active && dcnt == 4'h0));
         end
      end
   end
   // Done is entered only at completion; the end pulse may already be gone
   assign cpop = active && state == pbm_pkg::ST_DONE;
   // leftover read data dropped at completion
   assign dflush = cpop && !cur_write;
   assign dpop = cur_write ? (state == pbm_pkg::ST_DATA && bus_ta) : rd_pop;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= pbm_pkg::ST_IDLE;
         active <= 1'b0;
         cur_write <= 1'b0;
         addr <= 32'h0;
         left <= 13'h0;
         beat <= 2'h0;
         skip <= 2'h0;
         burst <= 1'b0;
         started <= 1'b0;
         discard <= 1'b0;
         pf_out <= 6'h0;
      end else begin
         case (state)
            pbm_pkg::ST_IDLE: begin
               if (!active && ccnt != 3'h0) begin
                  active <= 1'b1;
                  cur_write <= chead.write;
                  addr <= chead.addr;
                  left <= {1'b0, chead.dwords};
                  started <= 1'b0;
               end else if (active && (xfer_end && !cur_write)) begin
                  state <= pbm_pkg::ST_DONE;
               end else if (go) begin
                  started <= 1'b1;
                  state <= pbm_pkg::ST_ADDR;
                  beat <= 2'h0;
                  if (cur_write) begin
                     // tail shorter than a line as singles
                     burst <= at_line && left >= 13'h4;
                     skip <= 2'h0;
                  end else if (read_ahead_enable && addr[4:3] != 2'b11) begin
                     // offsets 1,2 burst from line start
                     burst <= 1'b1;
                     skip <= addr[4:3];
                  end else begin
                     burst <= at_line;
                     skip <= 2'h0;
                  end
               end
            end
            pbm_pkg::ST_ADDR: begin
               if (bus_grant && bus_aack) begin
                  state <= pbm_pkg::ST_DATA;
                  discard <= (skip != 2'h0);
               end
            end
            pbm_pkg::ST_DATA: begin
               if (bus_ta) begin
                  beat <= beat + 2'h1;
                  if (!discard) begin
                     addr <= addr + 32'h8;
                     left <= left - 13'h1;
                  end
                  discard <= (beat + 2'h1 < skip);
                  // four beats per burst, one otherwise
                  if (!burst || beat == 2'h3 || (!discard && left == 13'h1 && !burst))
                     state <= (left == 13'h1 && !discard) || xfer_end
                        ? pbm_pkg::ST_DONE : pbm_pkg::ST_IDLE;
               end
            end
            pbm_pkg::ST_DONE: begin
               if (cpop) begin
                  active <= 1'b0;
                  state <= pbm_pkg::ST_IDLE;
               end
            end
            default: state <= pbm_pkg::ST_IDLE;
         endcase
         if (!cur_write && state == pbm_pkg::ST_ADDR && bus_grant && bus_aack)
            pf_out <= burst ? pbm_pkg::PF_LINES_DW : 6'h1;
         else if (dpush && pf_out != 6'h0)
            pf_out <= pf_out - 6'h1;
      end
   end
   wire logic unused_to_line = |to_line;

   // =====================================================
   // Bus outputs
   always_ff @(posedge core_clk) begin
      if (srst) begin
         bus_out <= '0;
         bus_wdata <= 64'h0;
      end else begin
         // hog holds request for the whole transfer
         bus_out.req <= (hog_en && active) || state == pbm_pkg::ST_ADDR
            || (go && !(state == pbm_pkg::ST_ADDR && bus_aack));
         bus_out.addr <= burst && !cur_write ? {addr[31:5], 5'h00} : addr;
         bus_out.burst <= burst;
         if (cur_write)
            bus_out.ttype <= burst ? pbm_pkg::TT_WKILL : pbm_pkg::TT_WFLUSH;
         else
            bus_out.ttype <= invalidate_attr ? pbm_pkg::TT_RWITM : pbm_pkg::TT_READ;
         bus_out.global <= global_attr && active;
         bus_wdata <= dmem[drp];
      end
   end

   // =====================================================
   // PCI read return and register read
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdata_valid <= 1'b0;
         rdata_out <= 64'h0;
      end else begin
         rdata_valid <= !cur_write && active && (dcnt > {3'h0, rd_pop});
         rdata_out <= rd_pop ? dmem[drp + 3'h1] : dmem[drp];
      end
   end
   always_ff @(posedge core_clk) begin
      if (srst)
         reg_rdata <= 32'h0;
      else if (reg_rd) begin
         case (reg_addr)
            pbm_pkg::REG_ATTR: reg_rdata <= {22'h0, attr};
            pbm_pkg::REG_GCTL: reg_rdata <= {31'h0, hog_en};
            pbm_pkg::REG_STAT: reg_rdata <= {16'h0, 4'h0, state, 1'b0, ccnt, dcnt};
            pbm_pkg::REG_LIMIT: reg_rdata <= limit;
            default: reg_rdata <= 32'h0;
         endcase
      end else
         reg_rdata <= 32'h0;
   end

   // =====================================================
   // Checks
   AST_CMD_FULL: assert property (@(posedge core_clk) disable iff (srst)
      cfull |=> !cmd_ack) else $error("ack given with full command FIFO");
   AST_DCNT_MAX: assert property (@(posedge core_clk) disable iff (srst)
      dcnt <= pbm_pkg::CNT_FULL) else $error("data FIFO overflow");
   AST_WR_TYPE: assert property (@(posedge core_clk) disable iff (srst)
      bus_out.req && cur_write && !bus_out.burst |-> bus_out.ttype == pbm_pkg::TT_WFLUSH)
      else $error("single write type wrong");
   AST_RD_TYPE: assert property (@(posedge core_clk) disable iff (srst)
      bus_out.req && !cur_write && active |-> bus_out.ttype ==
      (invalidate_attr ? pbm_pkg::TT_RWITM : pbm_pkg::TT_READ)) else $error("read type wrong");
   AST_HOG: assert property (@(posedge core_clk) disable iff (srst)
      hog_en && active && $stable(hog_en) |=> bus_out.req) else $error("hog request dropped");
   AST_GBL: assert property (@(posedge core_clk) disable iff (srst)
      active && $stable(global_attr) && $past(active) |-> bus_out.global == global_attr)
      else $error("global mark wrong");
   AST_FLUSH: assert property (@(posedge core_clk) disable iff (srst)
      dflush |=> dcnt == 4'h0) else $error("read residue kept");
   AST_CCNT: assert property (@(posedge core_clk) disable iff (srst)
      ccnt <= 3'h4) else $error("command FIFO overflow");
endmodule // pbm_master

// *** bench/pbm_bus_model.sv ***
// Processor-bus arbiter and target model
`timescale 1ns/1ps
module pbm_bus_model #(
   parameter int DLY = 2
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire pbm_pkg::pbm_bus_t bus_out,
   output logic bus_grant,
   output logic bus_aack,
   output logic bus_ta,
   output logic [63:0] bus_rdata
);
   int wcnt;
   int beats;
   logic [31:0] ba;
   // =====================================================
   // Grant, address acknowledge and data beats
   // grant after a delay, then four beats or one
   always_ff @(posedge core_clk) begin
      bus_grant <= 1'b0;
      bus_aack <= 1'b0;
      bus_ta <= 1'b0;
      // Released data toggles so a stale beat never matches
      bus_rdata <= ~bus_rdata;
      if (srst) begin
         wcnt <= 0;
         beats <= 0;
         bus_rdata <= 64'h0;
      end else if (beats > 0) begin
         bus_ta <= 1'b1;
         bus_rdata <= {32'h0, ba};
         ba <= ba + 32'h8;
         beats <= beats - 1;
      end else if (bus_out.req && !bus_aack) begin
         wcnt <= wcnt + 1;
         if (wcnt >= DLY) begin
            bus_grant <= 1'b1;
            bus_aack <= 1'b1;
            wcnt <= 0;
            beats <= bus_out.burst ? 4 : 1;
            ba <= bus_out.burst ? {bus_out.addr[31:5], 5'h0} : bus_out.addr;
         end
      end else begin
         wcnt <= 0;
      end
   end
endmodule // pbm_bus_model

// *** bench/tb_top.sv ***
// Self-checking bench for the processor-bus master
`timescale 1ns/1ps
module tb_top;
   logic core_clk;
   logic srst;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic cmd_valid;
   pbm_pkg::pbm_cmd_t cmd_in;
   logic cmd_ack;
   logic wdata_valid;
   logic [63:0] wdata_in;
   logic wdata_ready;
   logic rdata_valid;
   logic [63:0] rdata_out;
   logic rdata_ready;
   logic pci_frame_active;
   logic xfer_end;
   pbm_pkg::pbm_bus_t bus_out;
   logic bus_grant;
   logic bus_aack;
   logic bus_ta;
   logic [63:0] bus_rdata;
   logic [63:0] bus_wdata;
   int err_count;
   int num_checks;
   pbm_pkg::pbm_bus_t txq[$];
   localparam logic [31:0] LIM = 32'h7F;

   pbm_master pbm_master_inst (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .cmd_valid, .cmd_in, .cmd_ack, .wdata_valid, .wdata_in, .wdata_ready,
      .rdata_valid, .rdata_out, .rdata_ready, .pci_frame_active, .xfer_end, .bus_out,
      .bus_grant, .bus_aack, .bus_ta, .bus_rdata, .bus_wdata);
   pbm_bus_model pbm_bus_model_inst (.core_clk, .srst, .bus_out, .bus_grant, .bus_aack,
      .bus_ta, .bus_rdata);

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (bus_aack && !srst) txq.push_back(bus_out);
   end

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic reg_wrt(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_rdx(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      d = reg_rdata;
   endtask
   task automatic send_cmd(input logic w, m, input logic [31:0] a, input logic [12:0] n,
         output logic ok);
      @(posedge core_clk);
      cmd_valid <= 1'b1;
      cmd_in <= {w, m, a, n[11:0]};
      ok = 1'b0;
      for (int i = 0; i < 20 && !ok; i++) begin
         @(posedge core_clk);
         ok = cmd_ack;
      end
      cmd_valid <= 1'b0;
   endtask
   task automatic feed(input logic [31:0] a, input int n);
      for (int i = 0; i < n; i++) begin
         wdata_valid <= 1'b1;
         wdata_in <= {32'h0, a + 32'(8 * i)};
         for (int t = 0; t < 80; t++) begin
            @(posedge core_clk);
            if (wdata_ready) break;
         end
      end
      wdata_valid <= 1'b0;
   endtask
   task automatic exp_tx(input logic [31:0] a, input logic [4:0] tt, input logic b, g);
      pbm_pkg::pbm_bus_t t;
      t = '0;
      for (int i = 0; i < 200 && txq.size() == 0; i++) @(posedge core_clk);
      if (txq.size() > 0) t = txq.pop_front();
      chk("bus transaction", {25'h0, a, tt, b, g}, {25'h0, t.addr, t.ttype, t.burst, t.global});
   endtask
   task automatic end_xfer();
      @(posedge core_clk);
      xfer_end <= 1'b1;
      @(posedge core_clk);
      xfer_end <= 1'b0;
      cyc(20);
      chk("extra transactions", 64'h0, 64'(txq.size()));
      txq.delete();
   endtask

   // =====================================================
   // Scenarios
   task automatic s_wprof();
      logic ok;
      reg_wrt(pbm_pkg::REG_ATTR, 32'h200);
      send_cmd(1'b1, 1'b0, 32'h8, 13'h7, ok);
      feed(32'h8, 7);
      exp_tx(32'h08, pbm_pkg::TT_WFLUSH, 1'b0, 1'b1);
      exp_tx(32'h10, pbm_pkg::TT_WFLUSH, 1'b0, 1'b1);
      exp_tx(32'h18, pbm_pkg::TT_WFLUSH, 1'b0, 1'b1);
      exp_tx(32'h20, pbm_pkg::TT_WKILL, 1'b1, 1'b1);
      end_xfer();
      reg_wrt(pbm_pkg::REG_ATTR, 32'h0);
      send_cmd(1'b1, 1'b0, 32'h0, 13'h6, ok);
      feed(32'h0, 6);
      exp_tx(32'h00, pbm_pkg::TT_WKILL, 1'b1, 1'b0);
      exp_tx(32'h20, pbm_pkg::TT_WFLUSH, 1'b0, 1'b0);
      exp_tx(32'h28, pbm_pkg::TT_WFLUSH, 1'b0, 1'b0);
      end_xfer();
   endtask
   task automatic s_thr();
      logic ok;
      int thr;
      for (int c = 0; c < 4; c++) begin
         // Codes needing over two lines start on a full FIFO
         thr = (c == 3) ? 4 : 8;
         reg_wrt(pbm_pkg::REG_ATTR, 32'h4 | 32'(c));
         send_cmd(1'b1, 1'b0, 32'h40, 13'h10, ok);
         feed(32'h40, thr - 1);
         cyc(10);
         chk("early request", 64'h0, 64'(bus_out.req));
         feed(32'h40 + 32'(8 * (thr - 1)), 17 - thr);
         for (int k = 0; k < 4; k++) exp_tx(32'h40 + 32'(32 * k), pbm_pkg::TT_WKILL, 1'b1, 1'b0);
         end_xfer();
      end
   endtask
   task automatic s_hog();
      logic ok;
      reg_wrt(pbm_pkg::REG_ATTR, 32'h0);
      for (int h = 1; h >= 0; h--) begin
         reg_wrt(pbm_pkg::REG_GCTL, 32'(h));
         send_cmd(1'b1, 1'b0, 32'h100, 13'h4, ok);
         cyc(10);
         chk("request with empty fifo", 64'(h), 64'(bus_out.req));
         feed(32'h100, 4);
         cyc(30);
         txq.delete();
         end_xfer();
      end
   endtask
   task automatic s_read(input logic ra, m, invalidate_attr, input logic [31:0] a, fa, input logic fb);
      logic ok;
      int n;
      pbm_pkg::pbm_bus_t t;
      n = 0;
      reg_wrt(pbm_pkg::REG_ATTR, {22'h0, 1'b0, invalidate_attr, 4'h0, ra, 3'h0});
      rdata_ready <= 1'b0;
      send_cmd(1'b0, m, a, 13'h8, ok);
      cyc(30);
      exp_tx(fa, invalidate_attr ? pbm_pkg::TT_RWITM : pbm_pkg::TT_READ, fb, 1'b0);
      if (!ra) chk("line before demand", 64'h0, 64'(txq.size()));
      rdata_ready <= 1'b1;
      for (int i = 0; i < 50; i++) begin
         @(posedge core_clk);
         if (rdata_valid) break;
      end
      chk("first read data", {32'h0, a}, rdata_out);
      // Drain the FIFO so the refill condition is reached
      for (int i = 0; i < 20; i++) begin
         @(posedge core_clk);
         if (!rdata_valid) break;
      end
      rdata_ready <= 1'b0;
      cyc(60);
      chk("next line fetched", 64'h1, 64'(txq.size() > 0));
      while (txq.size() > 0) begin
         t = txq.pop_front();
         chk("prefetch within limit", 64'h1, 64'(t.addr <= LIM));
      end
      end_xfer();
      rdata_ready <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         @(posedge core_clk);
         n += int'(rdata_valid === 1'b1);
      end
      chk("residual data", 64'h0, 64'(n));
   endtask
   task automatic s_full();
      logic ok;
      int n;
      n = 0;
      reg_wrt(pbm_pkg::REG_ATTR, 32'h4);
      for (int i = 0; i < 6; i++) begin
         send_cmd(1'b1, 1'b0, 32'h200, 13'h10, ok);
         if (ok) n++;
      end
      // Engine keeps its command in the FIFO until done, so four fill it
      chk("commands taken", 64'h1, 64'(n == 4 || n == 5));
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      give_verdict();
   end
   initial begin
      logic [31:0] d;
      {srst, reg_wr, reg_rd, cmd_valid, wdata_valid, rdata_ready, xfer_end} = 7'h40;
      {reg_addr, reg_wdata, cmd_in, wdata_in} = '0;
      pci_frame_active = 1'b1;
      err_count = 0;
      num_checks = 0;
      cyc(4);
      srst <= 1'b0;
      reg_rdx(pbm_pkg::REG_GCTL, d);
      chk("hog after reset", 64'h0, 64'(d));
      reg_rdx(pbm_pkg::REG_LIMIT, d);
      chk("limit after reset", 64'(pbm_pkg::LIMIT_RST), 64'(d));
      reg_rdx(4'h2, d);
      chk("unmapped read", 64'h0, 64'(d));
      s_wprof();
      s_thr();
      s_hog();
      reg_wrt(pbm_pkg::REG_GCTL, 32'h0);
      reg_wrt(pbm_pkg::REG_LIMIT, LIM);
      s_read(1'b1, 1'b0, 1'b1, 32'h08, 32'h00, 1'b1);
      s_read(1'b1, 1'b1, 1'b0, 32'h18, 32'h18, 1'b0);
      s_read(1'b0, 1'b0, 1'b0, 32'h00, 32'h00, 1'b1);
      s_full();
      give_verdict();
   end
endmodule // tb_top
